// file: logic/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ----------------------------------------
// Host bus placement of the control word
// ----------------------------------------
// Byte at base holds field bits 00..07 (most significant byte)
`define SAC_CTRL_BASE 8'h60
`define SAC_CTRL_BYTE3 8'h60
`define SAC_CTRL_BYTE2 8'h61
`define SAC_CTRL_BYTE1 8'h62
`define SAC_CTRL_BYTE0 8'h63

// ----------------------------------------
// Field positions as vector indices (field bit n sits at index 31-n)
// ----------------------------------------
`define SAC_BIT_MGMT_RST 30
`define SAC_BIT_CMD_RST 28
`define SAC_BIT_XFER_RST 26
`define SAC_BIT_STAT_SEND 23
`define SAC_BIT_ABORT 22
`define SAC_BIT_UNSOL 21
`define SAC_RESP_LSB 8
`define SAC_BIT_CSR_DIS 3
`define SAC_BIT_BACKPLANE 2
`define SAC_BIT_INIT_DONE 1
`define SAC_BIT_CFG_VALID 0

// ----------------------------------------
// Reset value and writable storage mask
// ----------------------------------------
`define SAC_CTRL_RESET 32'h00000000
`define SAC_CTRL_RW_MASK 32'h0000000f

`endif

// file: logic/sac_pkg.sv
package sac_pkg;

  // ----------------------------------------
  // Abort sequencing states
  // ----------------------------------------
  typedef enum logic [0:0] {
    SAC_ABORT_IDLE,
    SAC_ABORT_WAIT
  } sac_abort_state_t;

endpackage

// file: logic/sac_agent_control.sv
`timescale 1ns/1ps
`include "sac_map.svh"


module sac_agent_control (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic rom_load_done_in,
  input wire logic status_fifo_confirmed_in,
  input wire logic abort_done_in,
  input wire logic unsol_granted_in,
  output logic [7:0] host_rdata_out,
  output logic mgmt_agent_reset_out,
  output logic cmd_agent_reset_out,
  output logic xfer_reset_out,
  output logic xfer_block_size_clear_out,
  output logic status_send_out,
  output logic abort_command_out,
  output logic abort_status_send_out,
  output logic response_send_out,
  output logic [7:0] response_code_out,
  output logic csr_forward_out,
  output logic backplane_mode_out,
  output logic ack_tardy_out,
  output logic cfg_rom_auto_reply_out,
  output logic cfg_rom_to_ctrl_fifo_out
);

  // ----------------------------------------
  // Host bus decode
  // ----------------------------------------
  // One-hot byte lane for an address, zero when outside the word
  function automatic logic [3:0] lane_of(input logic [7:0] addr);
    logic [3:0] lane;
    lane = 4'h0;
    case (addr)
      `SAC_CTRL_BYTE3: lane = 4'h8;
      `SAC_CTRL_BYTE2: lane = 4'h4;
      `SAC_CTRL_BYTE1: lane = 4'h2;
      `SAC_CTRL_BYTE0: lane = 4'h1;
      default: lane = 4'h0;
    endcase
    return lane;
  endfunction

  logic [31:0] ctrl;
  logic unsol_q;
  logic status_armed;
  sac_pkg::sac_abort_state_t abort_state;
  sac_pkg::sac_abort_state_t next_abort_state;

  wire [3:0] lane = lane_of(host_addr_in);
  wire wr_hit = host_wr_in & (lane != 4'h0);
  wire [31:0] wword = {4{host_wdata_in}};
  wire [31:0] wmask = wr_hit ? {{8{lane[3]}}, {8{lane[2]}}, {8{lane[1]}}, {8{lane[0]}}}
                             : 32'h00000000;
  wire [31:0] ones_written = wword & wmask;

  // Only the four stored bits take write data; reserved lanes drop it
  wire [31:0] rw_mask = wmask & `SAC_CTRL_RW_MASK;
  wire [31:0] ctrl_wr = (ctrl & ~rw_mask) | (wword & rw_mask);
  // ROM load completion is applied after the write so the set wins
  wire [31:0] rom_set = rom_load_done_in ?
    ((32'h00000001 << `SAC_BIT_INIT_DONE) | (32'h00000001 << `SAC_BIT_CFG_VALID)) :
    32'h00000000;
  wire [31:0] next_ctrl = ctrl_wr | rom_set;

  // Readback: stored bits plus live unsolicited permission
  wire [31:0] rd_word = ctrl | ({31'h00000000, unsol_q} << `SAC_BIT_UNSOL);
  wire [7:0] rd_byte = lane[3] ? rd_word[31:24] :
                       lane[2] ? rd_word[23:16] :
                       lane[1] ? rd_word[15:8] :
                       lane[0] ? rd_word[7:0] : 8'h00;

  // Status arming and abort sequencing
  wire arm_req = ones_written[`SAC_BIT_STAT_SEND];
  wire stat_fire = status_armed & status_fifo_confirmed_in;
  wire abort_req = ones_written[`SAC_BIT_ABORT];
  wire abort_finish = (abort_state == sac_pkg::SAC_ABORT_WAIT) & abort_done_in;
  wire resp_req = wr_hit & lane[1];

  // ----------------------------------------
  // Abort next-state logic
  // ----------------------------------------
  always_comb begin
    next_abort_state = abort_state;
    case (abort_state)
      sac_pkg::SAC_ABORT_IDLE: begin
        if (abort_req) begin
          next_abort_state = sac_pkg::SAC_ABORT_WAIT;
        end
      end
      sac_pkg::SAC_ABORT_WAIT: begin
        if (abort_done_in) begin
          next_abort_state = sac_pkg::SAC_ABORT_IDLE;
        end
      end
      default: next_abort_state = sac_pkg::SAC_ABORT_IDLE;
    endcase
  end

  // ----------------------------------------
  // Stored control word and host read data
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ctrl <= `SAC_CTRL_RESET;
      unsol_q <= 1'b0;
      host_rdata_out <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      unsol_q <= unsol_granted_in;
      host_rdata_out <= host_rd_in ? rd_byte : 8'h00;
    end
  end

  // ----------------------------------------
  // Self-clearing strobes
  // ----------------------------------------
  // Strobes never store, so a reset bit reads back as zero next cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      mgmt_agent_reset_out <= 1'b0;
      cmd_agent_reset_out <= 1'b0;
      xfer_reset_out <= 1'b0;
      xfer_block_size_clear_out <= 1'b0;
    end else begin
      mgmt_agent_reset_out <= ones_written[`SAC_BIT_MGMT_RST];
      cmd_agent_reset_out <= ones_written[`SAC_BIT_CMD_RST];
      xfer_reset_out <= ones_written[`SAC_BIT_XFER_RST];
      xfer_block_size_clear_out <= ones_written[`SAC_BIT_XFER_RST];
    end
  end

  // ----------------------------------------
  // Status, abort and response triggers
  // ----------------------------------------
  // New arm request beats the clear caused by a send
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      status_armed <= 1'b0;
      status_send_out <= 1'b0;
      abort_state <= sac_pkg::SAC_ABORT_IDLE;
      abort_command_out <= 1'b0;
      abort_status_send_out <= 1'b0;
      response_send_out <= 1'b0;
      response_code_out <= 8'h00;
    end else begin
      status_armed <= arm_req | (status_armed & ~stat_fire);
      status_send_out <= stat_fire;
      abort_state <= next_abort_state;
      abort_command_out <= abort_req & (abort_state == sac_pkg::SAC_ABORT_IDLE);
      abort_status_send_out <= abort_finish;
      response_send_out <= resp_req;
      if (resp_req) begin
        response_code_out <= host_wdata_in;
      end
    end
  end

  // ----------------------------------------
  // Mode levels, taken from the next word so they track it exactly
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      csr_forward_out <= 1'b0;
      backplane_mode_out <= 1'b0;
      // Cleared word means not initialized and not valid, so ack_tardy_out and cfg_rom_to_ctrl_fifo_out stand high
      ack_tardy_out <= 1'b1;
      cfg_rom_auto_reply_out <= 1'b0;
      cfg_rom_to_ctrl_fifo_out <= 1'b1;
    end else begin
      csr_forward_out <= next_ctrl[`SAC_BIT_CSR_DIS];
      backplane_mode_out <= next_ctrl[`SAC_BIT_BACKPLANE];
      ack_tardy_out <= ~next_ctrl[`SAC_BIT_INIT_DONE];
      cfg_rom_auto_reply_out <= next_ctrl[`SAC_BIT_INIT_DONE] &
                                next_ctrl[`SAC_BIT_CFG_VALID];
      cfg_rom_to_ctrl_fifo_out <= ~next_ctrl[`SAC_BIT_CFG_VALID];
    end
  end

endmodule

// file: sim/sac_ctrl_props.sv
`timescale 1ns/1ps
module sac_ctrl_props (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic rom_load_done_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic mgmt_agent_reset_out,
  input wire logic xfer_reset_out,
  input wire logic response_send_out,
  input wire logic [7:0] response_code_out,
  input wire logic csr_forward_out,
  input wire logic ack_tardy_out
);
  // One domain, so clock and reset are set once
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_wr(a);
    host_wr_in && host_addr_in == a;
  endsequence
  property p_mgmt;
    s_wr(8'h60) ##0 host_wdata_in[6] |=> mgmt_agent_reset_out ##1 !mgmt_agent_reset_out;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("mgmt");
  property p_xfer; s_wr(8'h60) ##0 host_wdata_in[2] |=> xfer_reset_out; endproperty
  a_xfer: assert property (p_xfer) else $error("xfer");
  property p_resp;
    s_wr(8'h62) |=> response_send_out && response_code_out == $past(host_wdata_in);
  endproperty
  a_resp: assert property (p_resp) else $error("resp");
  property p_rom; rom_load_done_in |=> !ack_tardy_out; endproperty
  a_rom: assert property (p_rom) else $error("rom");
  property p_csr;
    host_wr_in && host_addr_in == 8'h63 |=> csr_forward_out == $past(host_wdata_in[3]);
  endproperty
  a_csr: assert property (p_csr) else $error("csr");
  property p_tardy;
    ack_tardy_out && !rom_load_done_in && !(host_wr_in && host_addr_in == 8'h63)
      |=> ack_tardy_out;
  endproperty
  a_tardy: assert property (p_tardy) else $error("tardy");
  property p_unm; host_rd_in && host_addr_in == 8'h64 |=> host_rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_res; host_rd_in && host_addr_in == 8'h63 |=> host_rdata_out[7:4] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("reserved");
endmodule
bind sac_agent_control sac_ctrl_props u_props (.*);

// file: sim/sac_initiator_model.sv
`timescale 1ns/1ps
module sac_initiator_model (
  input wire logic clk_sys_in,
  input wire logic enable_in,
  output logic unsol_granted_out
);
  // Grant follows the initiator's own decision a cycle later
  always_ff @(posedge clk_sys_in) begin
    unsol_granted_out <= enable_in;
  end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in = 0, rst_b_in = 0, host_wr_in = 0, host_rd_in = 0, en = 0;
  logic rom_load_done_in = 0, status_fifo_confirmed_in = 0, abort_done_in = 0;
  logic [7:0] host_addr_in = 8'h00, host_wdata_in = 8'h00, host_rdata_out, response_code_out;
  logic unsol_granted_in, mgmt_agent_reset_out, cmd_agent_reset_out, xfer_reset_out;
  logic xfer_block_size_clear_out, status_send_out, abort_command_out, abort_status_send_out;
  logic response_send_out, csr_forward_out, backplane_mode_out, ack_tardy_out;
  logic cfg_rom_auto_reply_out, cfg_rom_to_ctrl_fifo_out;
  int bad_count = 0, total_checks = 0;
  sac_agent_control u_dut (.*);
  sac_initiator_model u_init (.clk_sys_in(clk_sys_in), .enable_in(en),
    .unsol_granted_out(unsol_granted_in));
  // 100 MHz clock
  initial forever #5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    {host_wr_in, host_addr_in, host_wdata_in} = {1'b1, a, d};
    tick;
    host_wr_in = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick;
    {host_rd_in, host_addr_in} = {1'b1, a};
    tick;
    host_rd_in = 0;
    chk(host_rdata_out, e);
  endtask
  task automatic rst;
    rst_b_in = 0;
    repeat (16) tick;
    rst_b_in = 1;
  endtask
  task automatic t_reset;
    chk({ack_tardy_out, cfg_rom_to_ctrl_fifo_out}, 8'h03);
    for (int i = 0; i < 4; i++) begin
      rd(8'h60 + 8'(i), 8'h00);
    end
  endtask
  task automatic t_agent;
    wr(8'h60, 8'hff);
    chk({mgmt_agent_reset_out, cmd_agent_reset_out}, 8'h03);
    chk({xfer_reset_out, xfer_block_size_clear_out}, 8'h03);
    tick;
    chk({mgmt_agent_reset_out, cmd_agent_reset_out, xfer_reset_out}, 8'h00);
    rd(8'h60, 8'h00);
  endtask
  task automatic t_resp;
    logic [7:0] c [3] = '{8'h00, 8'ha5, 8'hff};
    foreach (c[i]) begin
      wr(8'h62, c[i]);
      chk({7'h00, response_send_out, response_code_out}, {8'h01, c[i]});
    end
  endtask
  task automatic t_stat;
    wr(8'h61, 8'h80);
    repeat (3) tick;
    chk(status_send_out, 8'h00);
    status_fifo_confirmed_in = 1;
    tick;
    status_fifo_confirmed_in = 0;
    chk(status_send_out, 8'h01);
    wr(8'h61, 8'h40);
    chk({abort_command_out, abort_status_send_out}, 8'h02);
    abort_done_in = 1;
    tick;
    abort_done_in = 0;
    chk(abort_status_send_out, 8'h01);
  endtask
  task automatic t_unsol;
    en = 1;
    // Grant passes the model and then the design's register before readback
    tick;
    rd(8'h61, 8'h20);
  endtask
  // Processor brings the part up by hand, no serial ROM
  task automatic t_cfg;
    wr(8'h63, 8'hfe);
    chk({csr_forward_out, backplane_mode_out, ack_tardy_out, cfg_rom_auto_reply_out,
      cfg_rom_to_ctrl_fifo_out}, 8'h19);
    rd(8'h63, 8'h0e);
    wr(8'h63, 8'h03);
    chk({csr_forward_out, backplane_mode_out, ack_tardy_out, cfg_rom_auto_reply_out,
      cfg_rom_to_ctrl_fifo_out}, 8'h02);
    rd(8'h64, 8'h00);
  endtask
  task automatic t_rom;
    rst;
    rom_load_done_in = 1;
    tick;
    rom_load_done_in = 0;
    chk({ack_tardy_out, cfg_rom_auto_reply_out, cfg_rom_to_ctrl_fifo_out}, 8'h02);
    rd(8'h63, 8'h03);
  endtask
  task automatic end_of_test;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    rst;
    t_reset;
    t_agent;
    t_resp;
    t_stat;
    t_unsol;
    t_cfg;
    t_rom;
    end_of_test;
  end
  // Run needs well under 2000 cycles
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule
